/* hdl/alu_unary_map.vh */
// Register offsets, status bit positions, opcodes and reset values for alu_unary.
// Assumes a byte-wide register port with an 8-bit address.
`ifndef ALU_UNARY_MAP_VH
`define ALU_UNARY_MAP_VH

// ==========================================
// Register offsets
`define OFS_ACC 8'h00
`define OFS_STATUS 8'h01
`define OFS_OPADDR 8'h02
`define OFS_CMD 8'h03
`define OFS_DMEM_BASE 8'h80

// ==========================================
// Status bit positions
`define ST_CARRY 0
`define ST_NIBBLE_CARRY 1
`define ST_ZERO 2
`define ST_POWER_DOWN 3
`define ST_WD_EXPIRY 4

// ==========================================
// Command codes
`define OP_INVERT_TO_ACC 3'h0
`define OP_BCD_FIXUP 3'h1
`define OP_SUB1_IN_MEM 3'h2
`define OP_SUB1_TO_ACC 3'h3
`define OP_POWER_DOWN 3'h4
`define OP_ADD1_IN_MEM 3'h5
`define OP_ADD1_TO_ACC 3'h6

// ==========================================
// Reset values and constants
`define ACC_RST 8'h00
`define STATUS_RST 5'h00
`define OPADDR_RST 7'h00
`define NIB_LIMIT 4'h9
`define NIB_FIX 4'h6

`endif

/* hdl/alu_unary.v */
// Single-operand execution datapath: complement, BCD fixup, decrement,
// increment and power-down entry, with its own data memory and status.
// Assumes one 200 MHz clock mclk, asynchronous active-low rstn, and a plain
// register port whose read data appear one cycle after the read strobe.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "alu_unary_map.vh"

module alu_unary #(
	parameter DMEM_DEPTH = 128
) (
	input wire mclk,
	input wire rstn,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire wake_pin,
	input wire wd_timeout_pin,
	output reg [7:0] rdata_q,
	output reg sys_clk_en_q,
	output reg wd_count_clr_q,
	output reg wd_prescale_clr_q
);

	// ==========================================
	// Helpers
	function zero8;
		input [7:0] v;
		begin
			zero8 = (v == 8'h00);
		end
	endfunction

	function nibble_over;
		input [3:0] n;
		begin
			nibble_over = (n > `NIB_LIMIT);
		end
	endfunction

	function [7:0] bcd_correction;
		input hi;
		input lo;
		begin
			bcd_correction = 8'h00;
			if (hi) begin
				bcd_correction[7:4] = `NIB_FIX;
			end
			if (lo) begin
				bcd_correction[3:0] = `NIB_FIX;
			end
		end
	endfunction

	function reg_hit;
		input strobe;
		input [7:0] a;
		input [7:0] ofs;
		begin
			reg_hit = strobe & (a == ofs);
		end
	endfunction

	function [7:0] pack_status;
		input cy;
		input nc;
		input z;
		input pd;
		input wx;
		begin
			pack_status = 8'h00;
			pack_status[`ST_CARRY] = cy;
			pack_status[`ST_NIBBLE_CARRY] = nc;
			pack_status[`ST_ZERO] = z;
			pack_status[`ST_POWER_DOWN] = pd;
			pack_status[`ST_WD_EXPIRY] = wx;
		end
	endfunction

	// ==========================================
	// State
	reg [7:0] dmem [0:DMEM_DEPTH-1];
	reg [7:0] acc_q;
	reg carry_q;
	reg nibble_carry_q;
	reg zero_q;
	reg power_down_flag_q;
	reg watchdog_expiry_flag_q;
	reg [6:0] opaddr_q;
	reg halted_q;
	reg wake_s1_q;
	reg wake_s2_q;
	reg wdt_s1_q;
	reg wdt_s2_q;
	reg wdt_s3_q;
	reg [7:0] acc_d;
	reg carry_d;
	reg nibble_carry_d;
	reg zero_d;
	reg power_down_flag_d;
	reg watchdog_expiry_flag_d;
	reg [6:0] opaddr_d;
	reg halted_d;
	reg sys_clk_en_d;
	reg wd_count_clr_d;
	reg wd_prescale_clr_d;
	reg [7:0] rdata_d;
	reg mem_we;
	reg [6:0] mem_waddr;
	reg [7:0] mem_wval;

	// ==========================================
	// Wake pin synchroniser
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wake_s1_q <= 1'b0;
			wake_s2_q <= 1'b0;
		end else begin
			wake_s1_q <= wake_pin;
			wake_s2_q <= wake_s1_q;
		end
	end

	// ==========================================
	// Watchdog timeout synchroniser and edge
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wdt_s1_q <= 1'b0;
			wdt_s2_q <= 1'b0;
			wdt_s3_q <= 1'b0;
		end else begin
			wdt_s1_q <= wd_timeout_pin;
			wdt_s2_q <= wdt_s1_q;
			wdt_s3_q <= wdt_s2_q;
		end
	end

	wire wdt_event = wdt_s2_q & ~wdt_s3_q;

	// ==========================================
	// Decode
	wire cmd_wr = reg_hit(wr, addr, `OFS_CMD) & ~halted_q;
	wire [2:0] op = wdata[2:0];
	wire [7:0] mem_op = dmem[opaddr_q];
	wire [7:0] inv_res = ~mem_op;
	wire [7:0] dec_res = mem_op - 8'h01;
	wire [7:0] inc_res = mem_op + 8'h01;
	wire lo_fix = nibble_over(acc_q[3:0]) | nibble_carry_q;
	wire hi_fix = nibble_over(acc_q[7:4]) | carry_q;
	wire [7:0] bcd_res = acc_q + bcd_correction(hi_fix, lo_fix);
	wire mem_in_range = (addr >= `OFS_DMEM_BASE);
	wire [6:0] mem_idx = addr[6:0];
	wire acc_wr = reg_hit(wr, addr, `OFS_ACC);
	wire status_wr = reg_hit(wr, addr, `OFS_STATUS);
	wire opaddr_wr = reg_hit(wr, addr, `OFS_OPADDR);

	// ==========================================
	// Command decode
	wire op_inv = cmd_wr & (op == `OP_INVERT_TO_ACC);
	wire op_bcd = cmd_wr & (op == `OP_BCD_FIXUP);
	wire op_sub1_mem = cmd_wr & (op == `OP_SUB1_IN_MEM);
	wire op_sub1_acc = cmd_wr & (op == `OP_SUB1_TO_ACC);
	wire op_pd = cmd_wr & (op == `OP_POWER_DOWN);
	wire op_add1_mem = cmd_wr & (op == `OP_ADD1_IN_MEM);
	wire op_add1_acc = cmd_wr & (op == `OP_ADD1_TO_ACC);

	// ==========================================
	// Data memory write port
	always @* begin
		mem_we = 1'b0;
		mem_waddr = mem_idx;
		mem_wval = wdata;
		if (wr & mem_in_range) begin
			mem_we = 1'b1;
		end else if (op_bcd) begin
			mem_we = 1'b1;
			mem_waddr = opaddr_q;
			mem_wval = bcd_res;
		end else if (op_sub1_mem) begin
			mem_we = 1'b1;
			mem_waddr = opaddr_q;
			mem_wval = dec_res;
		end else if (op_add1_mem) begin
			mem_we = 1'b1;
			mem_waddr = opaddr_q;
			mem_wval = inc_res;
		end
	end

	always @(posedge mclk) begin
		if (mem_we) begin
			dmem[mem_waddr] <= mem_wval;
		end
	end

	// ==========================================
	// Accumulator and arithmetic flags
	always @* begin
		acc_d = acc_q;
		carry_d = carry_q;
		nibble_carry_d = nibble_carry_q;
		zero_d = zero_q;
		opaddr_d = opaddr_q;
		if (acc_wr) begin
			acc_d = wdata;
		end
		if (opaddr_wr) begin
			opaddr_d = wdata[6:0];
		end
		if (status_wr) begin
			carry_d = wdata[`ST_CARRY];
			nibble_carry_d = wdata[`ST_NIBBLE_CARRY];
			zero_d = wdata[`ST_ZERO];
		end
		if (op_inv) begin
			acc_d = inv_res;
			zero_d = zero8(inv_res);
		end
		if (op_bcd) begin
			carry_d = carry_q | hi_fix;
		end
		if (op_sub1_mem) begin
			zero_d = zero8(dec_res);
		end
		if (op_sub1_acc) begin
			acc_d = dec_res;
			zero_d = zero8(dec_res);
		end
		if (op_add1_mem) begin
			zero_d = zero8(inc_res);
		end
		if (op_add1_acc) begin
			acc_d = inc_res;
			zero_d = zero8(inc_res);
		end
	end

	// ==========================================
	// Power-down control
	always @* begin
		halted_d = halted_q;
		sys_clk_en_d = sys_clk_en_q;
		power_down_flag_d = power_down_flag_q;
		wd_count_clr_d = 1'b0;
		wd_prescale_clr_d = 1'b0;
		if (halted_q & wake_s2_q) begin
			halted_d = 1'b0;
			sys_clk_en_d = 1'b1;
		end
		if (op_pd) begin
			halted_d = 1'b1;
			sys_clk_en_d = 1'b0;
			wd_count_clr_d = 1'b1;
			wd_prescale_clr_d = 1'b1;
			power_down_flag_d = 1'b1;
		end
	end

	// ==========================================
	// Watchdog expiry flag
	always @* begin
		watchdog_expiry_flag_d = watchdog_expiry_flag_q;
		// Expiry set wins over the power-down clear
		if (wdt_event) begin
			watchdog_expiry_flag_d = 1'b1;
		end else if (op_pd) begin
			watchdog_expiry_flag_d = 1'b0;
		end
	end

	// ==========================================
	// Registers
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_q <= `ACC_RST;
			carry_q <= 1'b0;
			nibble_carry_q <= 1'b0;
			zero_q <= 1'b0;
			power_down_flag_q <= 1'b0;
			watchdog_expiry_flag_q <= 1'b0;
			opaddr_q <= `OPADDR_RST;
			halted_q <= 1'b0;
			sys_clk_en_q <= 1'b1;
			wd_count_clr_q <= 1'b0;
			wd_prescale_clr_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			carry_q <= carry_d;
			nibble_carry_q <= nibble_carry_d;
			zero_q <= zero_d;
			power_down_flag_q <= power_down_flag_d;
			watchdog_expiry_flag_q <= watchdog_expiry_flag_d;
			opaddr_q <= opaddr_d;
			halted_q <= halted_d;
			sys_clk_en_q <= sys_clk_en_d;
			wd_count_clr_q <= wd_count_clr_d;
			wd_prescale_clr_q <= wd_prescale_clr_d;
		end
	end

	// ==========================================
	// Read port
	always @* begin
		rdata_d = 8'h00;
		if (rd & mem_in_range) begin
			rdata_d = dmem[mem_idx];
		end else if (rd) begin
			case (addr)
				`OFS_ACC: begin
					rdata_d = acc_q;
				end
				`OFS_STATUS: begin
					rdata_d = pack_status(carry_q, nibble_carry_q, zero_q, power_down_flag_q,
						watchdog_expiry_flag_q);
				end
				`OFS_OPADDR: begin
					rdata_d = {1'b0, opaddr_q};
				end
				`OFS_CMD: begin
					rdata_d = {7'h00, halted_q};
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

endmodule // alu_unary
`default_nettype wire

/* dv/alu_unary_properties.sv */
// Checker for alu_unary power-down and clear outputs.
// Assumes binding to alu_unary, one clock mclk.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks
module alu_unary_properties (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic wake_pin,
	input wire logic wd_timeout_pin,
	input wire logic [7:0] rdata_q,
	input wire logic sys_clk_en_q,
	input wire logic wd_count_clr_q,
	input wire logic wd_prescale_clr_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire pd = wr && addr == 8'h03 && wdata[2:0] == 3'h4;
	property p_halt; (!wake_pin)[*3] ##0 (pd && sys_clk_en_q) |=> !sys_clk_en_q && wd_count_clr_q; endproperty
	a_halt: assert property (p_halt) else $error("halt");
	property p_hold; (!wake_pin)[*4] ##0 !sys_clk_en_q |=> !sys_clk_en_q; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_wake; wake_pin[*8] |-> sys_clk_en_q; endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_pulse; wd_count_clr_q |=> !wd_count_clr_q; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_pair; wd_count_clr_q == wd_prescale_clr_q; endproperty
	a_pair: assert property (p_pair) else $error("pair");
	property p_cause; $rose(wd_count_clr_q) |-> $past(pd) && $past(sys_clk_en_q); endproperty
	a_cause: assert property (p_cause) else $error("cause");
	property p_fell; $fell(sys_clk_en_q) |-> wd_prescale_clr_q; endproperty
	a_fell: assert property (p_fell) else $error("fell");
	property p_flag; rd && addr == 8'h01 && !sys_clk_en_q |=> rdata_q[3]; endproperty
	a_flag: assert property (p_flag) else $error("flag");
	cover property (pd);
	cover property ($rose(sys_clk_en_q));
	cover property (rd && addr == 8'h01);
endmodule // alu_unary_properties
bind alu_unary alu_unary_properties i_props (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .wake_pin(wake_pin), .wd_timeout_pin(wd_timeout_pin), .rdata_q(rdata_q),
	.sys_clk_en_q(sys_clk_en_q), .wd_count_clr_q(wd_count_clr_q), .wd_prescale_clr_q(wd_prescale_clr_q));
`default_nettype wire

/* dv/alu_unary_tb.sv */
// Bench for alu_unary: unary op table, then power-down and wake.
// Assumes the checker is bound to the design.
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench
module alu_unary_tb;
	logic mclk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, wake_pin = 1'h0, wd_timeout_pin = 1'h0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	wire [7:0] rdata_q;
	wire sys_clk_en_q, wd_count_clr_q, wd_prescale_clr_q;
	int n_fail = 0, checks = 0;
	always #2.5 mclk = ~mclk;
	alu_unary i_dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.wake_pin(wake_pin), .wd_timeout_pin(wd_timeout_pin), .rdata_q(rdata_q),
		.sys_clk_en_q(sys_clk_en_q), .wd_count_clr_q(wd_count_clr_q), .wd_prescale_clr_q(wd_prescale_clr_q));
	task automatic summarize;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge mclk);
		wr <= 1'h0;
	endtask
	task automatic r(input logic [7:0] a, e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk);
		rd <= 1'h0;
		#1;
		chk(rdata_q, e);
	endtask
	task automatic run(input logic [7:0] op, m, a, s, ea, em, es);
		w(8'h85, m);
		w(8'h00, a);
		w(8'h01, s);
		w(8'h03, op);
		r(8'h00, ea);
		r(8'h85, em);
		r(8'h01, es);
	endtask
	task automatic wake;
		wake_pin <= 1'h1;
		for (int i = 0; i < 20 && sys_clk_en_q !== 1'h1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk({7'h00, sys_clk_en_q}, 8'h01);
		if (sys_clk_en_q !== 1'h1)
			summarize;
		wake_pin <= 1'h0;
		repeat (4) @(posedge mclk);
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'h1;
		w(8'h02, 8'h05);
		run(8'h00, 8'hff, 8'h12, 8'h00, 8'h00, 8'hff, 8'h04);
		run(8'h01, 8'h00, 8'h7b, 8'h00, 8'h7b, 8'h81, 8'h00);
		run(8'h01, 8'h00, 8'ha5, 8'h04, 8'ha5, 8'h05, 8'h05);
		run(8'h01, 8'h00, 8'h12, 8'h03, 8'h12, 8'h78, 8'h03);
		run(8'h01, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		run(8'h02, 8'h00, 8'h33, 8'h05, 8'h33, 8'hff, 8'h01);
		run(8'h03, 8'h01, 8'h33, 8'h00, 8'h00, 8'h01, 8'h04);
		run(8'h05, 8'hff, 8'h33, 8'h01, 8'h33, 8'h00, 8'h05);
		run(8'h06, 8'h7f, 8'h33, 8'h06, 8'h80, 8'h7f, 8'h02);
		$display("test unary ops done");
		w(8'h03, 8'h04);
		#1;
		chk({5'h00, sys_clk_en_q, wd_count_clr_q, wd_prescale_clr_q}, 8'h03);
		r(8'h01, 8'h0a);
		r(8'h03, 8'h01);
		w(8'h03, 8'h06);
		r(8'h00, 8'h80);
		wake;
		r(8'h03, 8'h00);
		wd_timeout_pin <= 1'h1;
		repeat (4) @(posedge mclk);
		r(8'h01, 8'h1a);
		w(8'h03, 8'h04);
		r(8'h01, 8'h0a);
		wake;
		$display("test power-down done");
		summarize;
	end
endmodule // alu_unary_tb
`default_nettype wire
